//--- src/sys_interrupt_lowpower_ctrl.sv
// Interrupt latch, arbitration, break flag protection and wait/stop control
//
// Behaviour
// - Interrupt entry stacks CPU registers and sets the mask; return restores them.
// - Requests are latched and arbitrated; result selects the vector fetched.
// - A latched request cannot be displaced until serviced or mask cleared.
// - Hardware requests are examined only after the current instruction completes.
// - Service only with mask clear and the source's enable set.
// - Highest pending first; pending at return is taken before next instruction.
// - Interrupt entry does not push the index high byte.
// - Software interrupt ignores the mask, ranks above every hardware source.
// - Software interrupt stacks PC, hardware interrupt stacks PC minus one.
// - Sources map to flags 1 to 16 in fixed priority order.
// - Each status flag reads 1 while its request is present.
// - Status one bits 1..0 and status three bits 7..2 read zero.
// - Reset overrides all interrupts and takes no part in arbitration.
// - Break request forces the CPU to the software interrupt vector.
// - In break, other flags clear only when break clear enable is set.
// - A flag cleared in break stays cleared after break ends.
// - Two-step clears stay protected in break; second step after break works.
// - Wait or stop clears the mask and stops CPU clock until wake.
// - Wait keeps peripheral clocks; wake stacks one cycle after the request.
// - Watchdog disable bit at 0 keeps the watchdog running, also in wait.
// - Stop holds counter reset, clocks off; generator off unless oscillator kept.
// - Stop recovery lasts 4096 cycles, or 32 when short; then stacking.
// - The system counter is 12 bits and times stop recovery.
`timescale 1ns/100ps
`default_nettype none
module sys_interrupt_lowpower_ctrl
  import sys_irq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral requests and their enables
  input  wire logic [15:0] irq_request,
  input  wire logic [15:0] irq_enable,
  // CPU core
  input  wire logic        cpu_mask,
  input  wire logic        instr_done,
  input  wire logic        swi_exec,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        rti_done,
  input  wire logic        int_ack,
  input  wire logic        break_request,
  output logic             int_start,
  output logic [4:0]       vector_sel,
  output logic             stack_pc_minus_one,
  output logic             push_index_high,
  output logic             set_mask,
  output logic             clear_mask,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             generator_clk_en,
  output logic             watchdog_run,
  output logic             break_state,
  output logic             flag_clear_allow
);
  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Lowest flag index wins: flag 1 is the highest priority source
  function automatic logic [4:0] pick_vector(input logic [15:0] req);
    logic [4:0] v;
    v = 5'h00;
    for (int i = NUM_HW_SOURCES - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = 5'(i + 1);
      end
    end
    return v;
  endfunction

  lp_state_e   state_q;
  logic [15:0] live_q;
  logic [11:0] sys_cnt_q;
  logic [11:0] recovery_last_q;
  logic        break_clear_enable_q;
  logic [2:0]  config_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [15:0] armed;
  logic        take_hw;
  logic        take_sw;
  logic        check_point;

  assign armed       = irq_request & irq_enable;
  assign check_point = instr_done | rti_done;
  assign take_sw     = swi_exec | break_request;
  assign take_hw     = !cpu_mask && (armed != 16'h0000);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reset is the async clear alone, so it always beats any request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q            <= ST_RUN;
      int_start          <= 1'b0;
      vector_sel         <= VEC_SOFTWARE;
      stack_pc_minus_one <= 1'b0;
      set_mask           <= 1'b0;
      clear_mask         <= 1'b0;
      recovery_last_q    <= RECOVERY_LONG_LAST;
    end else begin
      int_start  <= 1'b0;
      set_mask   <= 1'b0;
      clear_mask <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (check_point && take_sw) begin
            state_q            <= ST_STACK;
            int_start          <= 1'b1;
            set_mask           <= 1'b1;
            vector_sel         <= VEC_SOFTWARE;
            stack_pc_minus_one <= 1'b0;
          end else if (check_point && take_hw) begin
            state_q            <= ST_STACK;
            int_start          <= 1'b1;
            set_mask           <= 1'b1;
            vector_sel         <= pick_vector(armed);
            stack_pc_minus_one <= 1'b1;
          end else if (wait_exec) begin
            state_q    <= ST_WAIT;
            clear_mask <= 1'b1;
          end else if (stop_exec) begin
            state_q    <= ST_STOP;
            clear_mask <= 1'b1;
          end
        end
        ST_WAIT: begin
          // Mask was just cleared, so any enabled request wakes us
          if (break_request || armed != 16'h0000) begin
            state_q            <= ST_STACK;
            int_start          <= 1'b1;
            set_mask           <= 1'b1;
            vector_sel         <= break_request ? VEC_SOFTWARE : pick_vector(armed);
            stack_pc_minus_one <= !break_request;
          end
        end
        ST_STOP: begin
          if (break_request || armed != 16'h0000) begin
            state_q            <= ST_RECOVER;
            vector_sel         <= break_request ? VEC_SOFTWARE : pick_vector(armed);
            stack_pc_minus_one <= !break_request;
            recovery_last_q    <= config_q[BIT_SHORT_STOP_RECOVERY] ?
                                  RECOVERY_SHORT_LAST : RECOVERY_LONG_LAST;
          end
        end
        ST_RECOVER: begin
          // Latched vector is kept through recovery even if the request drops
          if (sys_cnt_q == recovery_last_q) begin
            state_q   <= ST_STACK;
            int_start <= 1'b1;
            set_mask  <= 1'b1;
          end
        end
        ST_STACK: begin
          // Held until the CPU has fetched the vector
          if (int_ack) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock gating and system counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_clk_en       <= 1'b1;
      periph_clk_en    <= 1'b1;
      generator_clk_en <= 1'b1;
    end else begin
      cpu_clk_en       <= (state_q == ST_RUN) || (state_q == ST_STACK);
      periph_clk_en    <= (state_q != ST_STOP) && (state_q != ST_RECOVER);
      generator_clk_en <= (state_q != ST_STOP) ||
                          config_q[BIT_OSCILLATOR_KEEP_IN_HALT];
    end
  end

  // Crystal clock is sys_clk here, so the counter steps once per cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_cnt_q <= 12'h000;
    end else if (state_q == ST_STOP) begin
      sys_cnt_q <= 12'h000;
    end else begin
      sys_cnt_q <= sys_cnt_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Break and status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      break_state      <= 1'b0;
      flag_clear_allow <= 1'b1;
      watchdog_run     <= 1'b1;
      live_q           <= 16'h0000;
      push_index_high  <= 1'b0;
    end else begin
      // Marked at the take, since the break line may drop before stacking
      if (break_request && ((state_q == ST_RUN && check_point) ||
                            state_q == ST_WAIT || state_q == ST_STOP)) begin
        break_state <= 1'b1;
      end else if (rti_done) begin
        break_state <= 1'b0;
      end
      // Peripherals gate their own clears; this only withholds them
      flag_clear_allow <= !break_state || break_clear_enable_q;
      watchdog_run     <= !config_q[BIT_WATCHDOG_DISABLE];
      live_q           <= irq_request;
      push_index_high  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q             <= 1'b0;
      w_got_q              <= 1'b0;
      aw_addr_q            <= 8'h00;
      w_data_q             <= 32'h0000_0000;
      w_strb_q             <= 4'h0;
      s_axi_awready        <= 1'b1;
      s_axi_wready         <= 1'b1;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= RESP_OKAY;
      break_clear_enable_q <= RST_BREAK_CLEAR_FLAG_ENABLE;
      config_q             <= RST_CONFIG;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q      <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q      <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        case (aw_addr_q)
          OFS_BREAK_FLAG_CTRL: begin
            if (w_strb_q[0]) begin
              break_clear_enable_q <= w_data_q[BIT_BREAK_CLEAR_FLAG_ENABLE];
            end
          end
          OFS_CONFIG: begin
            if (w_strb_q[0]) begin
              config_q <= w_data_q[2:0];
            end
          end
          OFS_IRQ_STATUS_ONE, OFS_IRQ_STATUS_TWO, OFS_IRQ_STATUS_THREE,
          OFS_LOWPOWER_STATUS: begin
            s_axi_bresp <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_q      <= 1'b0;
        w_got_q       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_IRQ_STATUS_ONE:   s_axi_rdata <= {24'h0, live_q[5:0], 2'b00};
        OFS_IRQ_STATUS_TWO:   s_axi_rdata <= {24'h0, live_q[13:6]};
        OFS_IRQ_STATUS_THREE: s_axi_rdata <= {30'h0, live_q[15:14]};
        OFS_BREAK_FLAG_CTRL:  s_axi_rdata <= {31'h0, break_clear_enable_q};
        OFS_CONFIG:           s_axi_rdata <= {29'h0, config_q};
        OFS_LOWPOWER_STATUS:  s_axi_rdata <= {19'h0, break_state, sys_cnt_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_stop_wake;
    state_q == ST_STOP && (break_request || armed != 16'h0000);
  endsequence
  // Quiet start of recovery, then stacking on the 33rd edge after wake
  sequence s_short_wait;
    !int_start [*8] ##25 int_start;
  endsequence

  a_entry_sets_mask: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(int_start) |-> set_mask) else $error("entry without mask set");
  a_vector_held: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_STACK && !int_ack |=> $stable(vector_sel)) else $error("latched vector moved");
  a_hw_waits_instr: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_RUN && !check_point |=> !int_start) else $error("hw taken mid instruction");
  a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_RUN && cpu_mask && !take_sw |=> !int_start) else $error("masked request taken");
  a_swi_vector: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_RUN && check_point && swi_exec |=> int_start && vector_sel == VEC_SOFTWARE
    && !stack_pc_minus_one) else $error("software interrupt not taken first");
  a_hw_priority: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_RUN && check_point && !take_sw && take_hw
    |=> vector_sel == pick_vector($past(armed)) && stack_pc_minus_one) else $error("bad priority");
  a_wait_wake: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_WAIT && armed != 16'h0000 |=> int_start ##1 cpu_clk_en) else $error("wait wake late");
  a_stop_short: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_stop_wake ##0 config_q[BIT_SHORT_STOP_RECOVERY] |=> s_short_wait) else $error("short recovery length");
  a_stop_counter: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_STOP |=> sys_cnt_q == 12'h000 && !periph_clk_en) else $error("counter runs in stop");
  a_break_protect: assert property (@(posedge sys_clk) disable iff (!arst_n)
    break_state && !break_clear_enable_q |=> !flag_clear_allow) else $error("flags unprotected in break");
  a_status_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_axi_rvalid && s_axi_rresp == RESP_OKAY && $past(s_axi_araddr) == OFS_IRQ_STATUS_THREE
    && $past(s_axi_arvalid) |-> s_axi_rdata[7:2] == 6'h00) else $error("reserved bits set");
  a_watchdog_wait: assert property (@(posedge sys_clk) disable iff (!arst_n)
    state_q == ST_WAIT && !config_q[BIT_WATCHDOG_DISABLE] |=> watchdog_run) else $error("watchdog stopped");
endmodule
`default_nettype wire

//--- src/sys_irq_pkg.sv
// Constants shared by the interrupt and low-power control block
package sys_irq_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_STATUS_ONE    = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS_TWO    = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS_THREE  = 8'h08;
  localparam logic [7:0] OFS_BREAK_FLAG_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_CONFIG            = 8'h10;
  localparam logic [7:0] OFS_LOWPOWER_STATUS   = 8'h14;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_BREAK_CLEAR_FLAG_ENABLE   = 0;
  localparam int BIT_SHORT_STOP_RECOVERY       = 0;
  localparam int BIT_OSCILLATOR_KEEP_IN_HALT   = 1;
  localparam int BIT_WATCHDOG_DISABLE          = 2;
  localparam logic       RST_BREAK_CLEAR_FLAG_ENABLE = 1'b0;
  localparam logic [2:0] RST_CONFIG                  = 3'h0;
  // ----------------------------------------------------------------
  // Timing, in crystal clock cycles
  // ----------------------------------------------------------------
  localparam int          SYS_COUNTER_WIDTH   = 12;
  localparam int          STOP_RECOVERY_LONG  = 4096;
  localparam int          STOP_RECOVERY_SHORT = 32;
  localparam logic [11:0] RECOVERY_LONG_LAST  = 12'(STOP_RECOVERY_LONG - 1);
  localparam logic [11:0] RECOVERY_SHORT_LAST = 12'(STOP_RECOVERY_SHORT - 1);
  // ----------------------------------------------------------------
  // Vector selection and bus answers
  // ----------------------------------------------------------------
  localparam int         NUM_HW_SOURCES = 16;
  localparam logic [4:0] VEC_SOFTWARE   = 5'h00;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  typedef enum {ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER, ST_STACK} lp_state_e;
endpackage

//--- tb/cpu_model.sv
// CPU core model: stacks after an interrupt start, then fetches the vector
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic int_start,
  output logic      int_ack
);
  int unsigned cnt_q;
  // Stacking time varies, so prompt and slow answers both occur
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q   <= 0;
      int_ack <= 1'b0;
    end else begin
      int_ack <= (cnt_q == 1);
      if (int_start) cnt_q <= 2 + ($urandom % 5);
      else if (cnt_q != 0) cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/test_sys_interrupt_lowpower_ctrl.sv
// Self-checking bench for the interrupt and low-power control block
`timescale 1ns/100ps
`default_nettype none
module test_sys_interrupt_lowpower_ctrl;
  import sys_irq_pkg::*;
  logic        sys_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, cpu_mask, instr_done, swi_exec, wait_exec, stop_exec, rti_done;
  logic        int_ack, break_request, int_start, stack_pc_minus_one, push_index_high;
  logic        set_mask, clear_mask, cpu_clk_en, periph_clk_en, generator_clk_en;
  logic        watchdog_run, break_state, flag_clear_allow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] irq_request, irq_enable;
  logic [4:0]  vector_sel;
  logic [33:0] rq[$], iq[$];
  int          fail_count, checked;

  sys_interrupt_lowpower_ctrl dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_request, .irq_enable,
    .cpu_mask, .instr_done, .swi_exec, .wait_exec, .stop_exec, .rti_done, .int_ack,
    .break_request, .int_start, .vector_sel, .stack_pc_minus_one, .push_index_high,
    .set_mask, .clear_mask, .cpu_clk_en, .periph_clk_en, .generator_clk_en,
    .watchdog_run, .break_state, .flag_clear_allow);
  cpu_model cpu (.sys_clk, .arst_n, .int_start, .int_ack);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Order: instr_done, swi, wait, stop, rti
  task automatic pulse(input logic [4:0] p);
    {instr_done, swi_exec, wait_exec, stop_exec, rti_done} <= p;
    tick(1);
    {instr_done, swi_exec, wait_exec, stop_exec, rti_done} <= 5'h00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(1);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    // Ready stays high so back-to-back calls never drive it twice at once
    chk(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(1);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask
  // Edges from request change to the stacking start
  task automatic wake(output int n);
    n = 0;
    while (int_start !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
  endtask

  // ------------------------------------------------------------
  // Result monitors
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata},
      rq.pop_front());
    // An entry nobody expected compares against all ones
    if (int_start === 1'b1) chk({28'h0, vector_sel, stack_pc_minus_one},
      iq.size() > 0 ? iq.pop_front() : '1);
  end

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    fail_count++;
    results();
  end

  initial begin
    int          n;
    logic [31:0] r;
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, irq_request, irq_enable} = '0;
    {cpu_mask, instr_done, swi_exec, wait_exec, stop_exec, rti_done, break_request} = '0;
    s_axi_wstrb = 4'h1;
    r = $urandom(35447);
    tick(10);
    arst_n <= 1'b1;
    tick(1);
    chk(watchdog_run, 1'b1);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      irq_request <= r[15:0];
      tick(1);
      rd(OFS_IRQ_STATUS_ONE, {RESP_OKAY, 24'h0, r[5:0], 2'h0});
      rd(OFS_IRQ_STATUS_TWO, {RESP_OKAY, 24'h0, r[13:6]});
      rd(OFS_IRQ_STATUS_THREE, {RESP_OKAY, 30'h0, r[15:14]});
    end
    wr(OFS_IRQ_STATUS_ONE, 32'hff, RESP_OKAY);
    rd(OFS_IRQ_STATUS_ONE, {RESP_OKAY, 24'h0, r[5:0], 2'h0});
    wr(8'h40, 32'h1, RESP_SLVERR);
    rd(8'h40, {RESP_SLVERR, 32'h0});
    // Enabled requests wait for the instruction boundary
    irq_request <= 16'h0225;
    irq_enable  <= 16'h0224;
    tick(4);
    iq.push_back({28'h0, 5'h03, 1'b1});
    pulse(5'h10);
    tick(1);
    chk(push_index_high, 1'b0);
    tick(8);
    iq.push_back({28'h0, 5'h03, 1'b1});
    pulse(5'h01);
    tick(8);
    cpu_mask <= 1'b1;
    pulse(5'h10);
    tick(4);
    iq.push_back(34'h0);
    pulse(5'h18);
    tick(8);
    cpu_mask      <= 1'b0;
    irq_enable    <= 16'h0000;
    break_request <= 1'b1;
    iq.push_back(34'h0);
    pulse(5'h10);
    break_request <= 1'b0;
    tick(8);
    chk({break_state, flag_clear_allow}, 2'h2);
    wr(OFS_BREAK_FLAG_CTRL, 32'h1, RESP_OKAY);
    tick(2);
    chk(flag_clear_allow, 1'b1);
    wr(OFS_BREAK_FLAG_CTRL, 32'h0, RESP_OKAY);
    pulse(5'h01);
    tick(2);
    chk({break_state, flag_clear_allow}, 2'h1);
    wr(OFS_CONFIG, 32'h4, RESP_OKAY);
    tick(2);
    chk(watchdog_run, 1'b0);
    rd(OFS_CONFIG, {RESP_OKAY, 32'h4});
    wr(OFS_CONFIG, 32'h0, RESP_OKAY);
    irq_request <= 16'h0000;
    irq_enable  <= 16'h0010;
    pulse(5'h04);
    tick(1);
    chk(clear_mask, 1'b1);
    tick(3);
    chk({cpu_clk_en, periph_clk_en, watchdog_run}, 3'h3);
    iq.push_back({28'h0, 5'h05, 1'b1});
    irq_request <= 16'h0010;
    wake(n);
    chk(n == 2, 1'b1);
    tick(8);
    // Short run keeps the oscillator, long run lets it stop
    for (int s = 1; s >= 0; s--) begin
      irq_request <= 16'h0000;
      wr(OFS_CONFIG, s ? 32'h3 : 32'h0, RESP_OKAY);
      pulse(5'h02);
      tick(4);
      chk({cpu_clk_en, periph_clk_en, generator_clk_en}, 3'(s));
      iq.push_back({28'h0, 5'h05, 1'b1});
      irq_request <= 16'h0010;
      wake(n);
      r = s ? STOP_RECOVERY_SHORT : STOP_RECOVERY_LONG;
      chk(n > r && n <= r + 4, 1'b1);
      tick(10);
      chk(cpu_clk_en, 1'b1);
    end
    results();
  end
endmodule
`default_nettype wire
